// ===== include/aism_pkg.sv
// Constants and carrier types for the audio interrupt status and mask block.
// Assumes a serial control port decoder that presents one register access per strobe.
package aism_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_CONV_MASK   = 7'h1B;
    localparam logic [6:0] ADDR_STATUS      = 7'h1C;
    localparam logic [6:0] ADDR_STATUS_MASK = 7'h1D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_LEFT_OVERFLOW   = 2;
    localparam int BIT_RIGHT_OVERFLOW  = 1;
    localparam int BIT_MUTE_INDICATE   = 0;
    localparam int BIT_CONVERTER_SUM   = 7;
    localparam int BIT_TX_CS_COLLISION = 6;
    localparam int BIT_TX_USERBIT_EMPTY = 5;
    localparam int BIT_TX_CS_DONE      = 4;
    localparam int BIT_RX_CS_DIFF      = 3;
    localparam int BIT_RX_USERBIT      = 2;
    localparam int BIT_RX_CS_BLOCK     = 1;
    localparam int BIT_RECEIVER_SUM    = 0;

    // Writable bits; reserved bits read as zero
    localparam logic [7:0] CONV_MASK_RW   = 8'h07;
    localparam logic [7:0] STATUS_MASK_RW = 8'hF7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONV_MASK   = 8'h00;
    localparam logic [7:0] RST_STATUS      = 8'h00;
    localparam logic [7:0] RST_STATUS_MASK = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       rd;
        logic       wr;
    } aism_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic       rvalid;
    } aism_rsp_t;

    // Converter flags for status bit 7, then event sources for status bits 6..0 in status order
    typedef struct packed {
        logic [2:0] conv_flags;
        logic [6:0] sources;
    } aism_evt_t;

endpackage

// ===== design/aism_flags.sv
// Bank of sticky flags: set by hardware events, cleared as a group.
// Assumes set and clear arrive from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module aism_flags #(
    parameter int          WIDTH     = 8,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             clr,
    // State
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] next_q;

    // Set beats a clear in the same cycle so no event is lost
    always_comb begin
        next_q = clr ? set : (q | set);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_VALUE;
        end else begin
            q <= next_q;
        end
    end

endmodule // aism_flags

`default_nettype wire

// ===== design/aism_top.sv
// Interrupt status, converter mask and status mask registers with interrupt output.
// Assumes the serial port decoder issues single-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none

module aism_top (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Register access from the serial control port
    input  wire aism_pkg::aism_req_t req,
    output var  aism_pkg::aism_rsp_t rsp,
    // Event sources from converter, receiver and transmitter
    input  wire aism_pkg::aism_evt_t evt,
    // Interrupt to host
    output var  logic               irq
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] conv_mask;
    logic [7:0] status_mask;
    logic [7:0] next_conv_mask;
    logic [7:0] next_status_mask;
    logic [7:0] status_q;
    logic [7:0] status_set;
    logic       status_rd;
    logic       conv_hit;
    aism_pkg::aism_rsp_t next_rsp;
    logic       next_irq;

    function automatic logic [7:0] merge_write(input logic [7:0] old,
                                               input logic [7:0] wdata,
                                               input logic [7:0] rw);
        merge_write = (old & ~rw) | (wdata & rw);
    endfunction

    always_comb begin
        next_conv_mask   = conv_mask;
        next_status_mask = status_mask;
        if (req.wr && req.addr == aism_pkg::ADDR_CONV_MASK) begin
            next_conv_mask = merge_write(conv_mask, req.wdata, aism_pkg::CONV_MASK_RW);
        end
        if (req.wr && req.addr == aism_pkg::ADDR_STATUS_MASK) begin
            next_status_mask = merge_write(status_mask, req.wdata, aism_pkg::STATUS_MASK_RW);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_mask   <= aism_pkg::RST_CONV_MASK;
            status_mask <= aism_pkg::RST_STATUS_MASK;
        end else begin
            conv_mask   <= next_conv_mask;
            status_mask <= next_status_mask;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_comb begin
        conv_hit   = |(evt.conv_flags & conv_mask[2:0]);
        status_set = {conv_hit, evt.sources};
        status_rd  = req.rd && req.addr == aism_pkg::ADDR_STATUS;
    end

    aism_flags #(
        .WIDTH     (8),
        .RST_VALUE (aism_pkg::RST_STATUS)
    ) u_status (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .set     (status_set),
        .clr     (status_rd),
        .q       (status_q)
    );

    // ------------------------------------------------------------
    // Read path and interrupt
    // ------------------------------------------------------------
    always_comb begin
        next_rsp.rvalid = req.rd;
        next_rsp.rdata  = aism_pkg::RDATA_UNMAPPED;
        if (req.rd) begin
            unique case (req.addr)
                aism_pkg::ADDR_CONV_MASK:   next_rsp.rdata = conv_mask;
                aism_pkg::ADDR_STATUS:      next_rsp.rdata = status_q;
                aism_pkg::ADDR_STATUS_MASK: next_rsp.rdata = status_mask;
                default:                    next_rsp.rdata = aism_pkg::RDATA_UNMAPPED;
            endcase
        end
        // Registered, so the pin lags the flag by one cycle
        next_irq = |(status_q & status_mask);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp <= '0;
            irq <= 1'b0;
        end else begin
            rsp <= next_rsp;
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_conv_gate_set: assert property (
        (evt.conv_flags & conv_mask[2:0]) != 3'h0 |=> status_q[7])
        else $error("enabled converter flag did not set summary");

    a_conv_gate_block: assert property (
        (evt.conv_flags & conv_mask[2:0]) == 3'h0 && (status_rd || !status_q[7])
        |=> !status_q[7])
        else $error("converter summary set without enabled flag");

    a_rx_summary_set: assert property (
        evt.sources[0] |=> status_q[0])
        else $error("receiver summary not set");

    a_flags_sticky: assert property (
        !status_rd |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("status flag dropped without status read");

    a_read_clears: assert property (
        status_rd && status_set == 8'h00 |=> status_q == 8'h00 && rsp.rvalid
        && rsp.rdata == $past(status_q))
        else $error("status read did not return and clear flags");

    a_txub_enable: assert property (
        status_q[5] && status_mask[5] |=> irq)
        else $error("enabled user-bit empty flag did not interrupt");

    a_rxcs_enable: assert property (
        status_q[1] && status_mask[1] |=> irq)
        else $error("enabled channel-status block flag did not interrupt");

    a_txcst_enable: assert property (
        status_q[6] && status_mask[6] |=> irq)
        else $error("enabled collision flag did not interrupt");

    a_irq_cause: assert property (
        (status_q & status_mask) == 8'h00 |=> !irq)
        else $error("interrupt without unmasked flag");

    c_read_clear: cover property (status_q != 8'h00 ##1 status_rd ##1 status_q == 8'h00);
    c_irq_rise:   cover property (!irq ##1 irq);
    c_set_on_clr: cover property (status_rd && status_set != 8'h00);

endmodule // aism_top

`default_nettype wire

// ===== bench/aism_host.sv
// Host model driving register strobes toward the interrupt status block.
// Assumes the block samples req on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none

module aism_host (
    // Clock
    input  wire logic                sys_clk,
    // Register access
    output var  aism_pkg::aism_req_t req,
    input  wire aism_pkg::aism_rsp_t rsp
);
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    initial begin
        req = '0;
    end

    // Released lines show the inverse, so stale values cannot pass
    task automatic drop(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: ~a, wdata: ~d, rd: 1'b0, wr: 1'b0};
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, rd: 1'b0, wr: 1'b1};
        drop(a, d);
    endtask

    // Status is read at once after every event burst except the one just before the mid-run reset
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
        drop(a, 8'h00);
        #1;
        while (rsp.rvalid !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        d = (rsp.rvalid === 1'b1) ? rsp.rdata : 8'hXX;
    endtask
endmodule // aism_host

`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the interrupt status and mask block.
// Assumes the host model owns req; the bench drives events directly.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                sys_clk;
    logic                rst_n;
    aism_pkg::aism_req_t req;
    aism_pkg::aism_rsp_t rsp;
    aism_pkg::aism_evt_t evt;
    logic                irq;
    int                  miscompares;
    int                  checks_done;
    logic [15:0]         lfsr;

    aism_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rsp(rsp), .evt(evt), .irq(irq));
    aism_host i_host (.sys_clk(sys_clk), .req(req), .rsp(rsp));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] exp_irq(input logic [7:0] st, input logic [7:0] m);
        return {7'h00, |(st & m & aism_pkg::STATUS_MASK_RW)};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        i_host.read_reg(a, d);
        check(d, exp, what);
    endtask

    // Events last one cycle; irq has settled two cycles later
    task automatic fire(input logic [2:0] c, input logic [6:0] s);
        @(posedge sys_clk);
        evt <= '{conv_flags: c, sources: s};
        @(posedge sys_clk);
        evt <= '0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [7:0] m;
        logic [7:0] s;
        logic [2:0] cm;
        int         i;
        logic [7:0] d;
        rst_n = 1'b0;
        evt = '0;
        miscompares = 0;
        checks_done = 0;
        lfsr = 16'hD415;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(aism_pkg::ADDR_CONV_MASK, aism_pkg::RST_CONV_MASK, "conv mask reset");
        rd_chk(aism_pkg::ADDR_STATUS, aism_pkg::RST_STATUS, "status reset");
        rd_chk(aism_pkg::ADDR_STATUS_MASK, aism_pkg::RST_STATUS_MASK, "status mask reset");
        rd_chk(7'h10, aism_pkg::RDATA_UNMAPPED, "unmapped read");
        i_host.write_reg(aism_pkg::ADDR_STATUS, 8'hFF);
        rd_chk(aism_pkg::ADDR_STATUS, 8'h00, "status not writable");
        $display("Test reset values done");
        for (i = 0; i < 3; i++) begin
            i_host.write_reg(aism_pkg::ADDR_CONV_MASK, 8'h01 << i);
            fire(~(3'h1 << i), 7'h00);
            rd_chk(aism_pkg::ADDR_STATUS, 8'h00, "masked conv flag");
            fire(3'h1 << i, 7'h00);
            rd_chk(aism_pkg::ADDR_STATUS, 8'h80, "enabled conv flag");
        end
        $display("Test converter gating done");
        for (i = 0; i < 7; i++) begin
            i_host.write_reg(aism_pkg::ADDR_STATUS_MASK, ~(8'h01 << i));
            fire(3'h0, 7'h01 << i);
            check({7'h00, irq}, 8'h00, "masked source irq");
            rd_chk(aism_pkg::ADDR_STATUS, 8'h01 << i, "source status");
            i_host.write_reg(aism_pkg::ADDR_STATUS_MASK, 8'h01 << i);
            fire(3'h0, 7'h01 << i);
            check({7'h00, irq}, {7'h00, i != 3}, "enabled source irq");
            rd_chk(aism_pkg::ADDR_STATUS, 8'h01 << i, "source status");
        end
        // Event lands on the same edge as the status read: set must win
        fork
            i_host.read_reg(aism_pkg::ADDR_STATUS, d);
            fire(3'h0, 7'h20);
        join
        check(d, 8'h00, "read with event");
        rd_chk(aism_pkg::ADDR_STATUS, 8'h20, "set beats clear");
        $display("Test per-source masks done");
        i_host.write_reg(aism_pkg::ADDR_STATUS_MASK, 8'hF7);
        fire(3'h0, 7'h7F);
        check({7'h00, irq}, exp_irq(8'h7F, 8'hF7), "irq before reset");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        check({7'h00, irq}, 8'h00, "irq after reset");
        rd_chk(aism_pkg::ADDR_STATUS_MASK, aism_pkg::RST_STATUS_MASK, "mask after reset");
        rd_chk(aism_pkg::ADDR_STATUS, aism_pkg::RST_STATUS, "status after reset");
        rd_chk(aism_pkg::ADDR_CONV_MASK, aism_pkg::RST_CONV_MASK, "conv after reset");
        $display("Test mid-run reset done");
        for (i = 0; i < 40; i++) begin
            lfsr = next_rand(lfsr);
            m = lfsr[7:0];
            cm = lfsr[10:8];
            i_host.write_reg(aism_pkg::ADDR_STATUS_MASK, m);
            rd_chk(aism_pkg::ADDR_STATUS_MASK, m & aism_pkg::STATUS_MASK_RW, "mask readback");
            // Upper bits random too, so reserved bits must read back as zero
            i_host.write_reg(aism_pkg::ADDR_CONV_MASK, lfsr[15:8]);
            rd_chk(aism_pkg::ADDR_CONV_MASK, lfsr[15:8] & aism_pkg::CONV_MASK_RW,
                   "conv readback");
            lfsr = next_rand(lfsr);
            s = {|(lfsr[10:8] & cm), lfsr[6:0]};
            fire(lfsr[10:8], lfsr[6:0]);
            check({7'h00, irq}, exp_irq(s, m), "irq level");
            rd_chk(aism_pkg::ADDR_STATUS, s, "sticky status");
            repeat (2) @(posedge sys_clk);
            #1;
            check({7'h00, irq}, 8'h00, "irq after read");
        end
        $display("Test random events done");
        wrap_up();
    end
endmodule // testbench

`default_nettype wire
